//--- hw/sbtc_top.v
// Overview of operation
// RULE1: clock select clear gives timer mode, counting system clock divided by four.
// RULE2: timer mode ignores the sync disable bit.
// RULE3: clock select set counts rising edges of oscillator pin or external clock pin.
// RULE4: sync disable clear aligns the count clock to phases, after the prescaler.
// RULE5: prescaler is a ripple divider ahead of the synchronizer, symmetrical output.
// RULE6: prescale field 00,01,10,11 divides by 1, 2, 4, 8.
// RULE7: synchronized counter holds in sleep while the prescaler keeps counting.
// RULE8: prescaler output sampled on phase two and phase four; increment follows.
// RULE9: at 1:1 sync mode, external clock high and low at least two periods.
// RULE10: above 1:1, external clock period at least four periods over prescale.
// RULE11: sync disable set counts unaligned, runs in sleep, overflow can wake.
// RULE12: asynchronous counter mode is no time base for capture or compare.
// RULE13: reading either count byte while counting returns a valid byte.
// RULE14: software reads high, low, high and repeats when high bytes differ.
// RULE15: software should stop the counter before writing the count bytes.
// RULE16: oscillator enable starts the low power crystal oscillator, runs in sleep.
// RULE17: software waits its own start-up delay after enabling the oscillator.
// RULE18: counts while timer on, wraps FFFF to 0000, sets overflow flag on wrap.
// RULE19: count is readable and writable as separate high and low byte registers.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_consts.vh"

module sbtc_top (
	// clock and reset
	input  wire        clk_sys,
	input  wire        resetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output wire        pslverr,
	output reg  [31:0] prdata,
	// core power state
	input  wire        sleep_mode,
	// oscillator input pin (shared)
	input  wire        osc_input_shared_pin,
	// clock input / oscillator amplifier pin (shared, two-way)
	input  wire        clock_input_shared_pin_i,
	output reg         clock_input_shared_pin_o,
	output reg         clock_input_shared_pin_oe,
	// time base for capture and compare
	output reg  [15:0] count_value,
	output reg         timebase_valid,
	// overflow
	output reg         overflow_flag,
	output reg         overflow_wake
);

	// bus decode
	wire [7:0]  bus_index;
	wire        addr_aligned;
	wire        hit_status;
	wire        hit_lo;
	wire        hit_hi;
	wire        hit_ctl;
	wire        hit_any;
	wire        setup_rd;
	wire        wr_en;
	wire        wr_ctl;
	wire        wr_status;
	wire        wr_lo;
	wire        wr_hi;
	wire        presc_clear;
	reg  [7:0]  rd_byte;

	// control
	reg  [7:0]  control_reg;
	wire        timer_on;
	wire        clock_source_select;
	wire        sync_disable;
	wire        osc_enable;
	wire [1:0]  prescale_select;
	wire        mode_timer;
	wire        mode_sync;
	wire        mode_async;

	// pins after two flip-flops
	wire [1:0]  pins_sync;
	wire        osc_input_pin;
	wire        ext_count_clock_pin;

	// instruction phases
	reg  [1:0]  phase_reg;
	wire        phase_two;
	wire        phase_four;

	// prescaler
	reg         src_reg;
	reg         src_prev_reg;
	wire        src_rise;
	reg  [2:0]  presc_reg;
	reg  [2:0]  presc_next;
	reg         presc_out;
	reg         presc_out_prev_reg;
	wire        presc_rise;

	// phase synchroniser
	reg         samp_reg;
	reg         samp_prev_reg;
	wire        samp_rise;

	// counter
	reg  [15:0] count_reg;
	reg  [15:0] count_next;
	reg         tick;
	wire        wrap;
	reg         ovf_reg;
	reg         ovf_next;

	assign bus_index    = paddr[9:2];
	assign addr_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
	assign hit_status   = addr_aligned && (bus_index == `SBTC_IDX_STATUS);
	assign hit_lo       = addr_aligned && (bus_index == `SBTC_IDX_COUNT_LO);
	assign hit_hi       = addr_aligned && (bus_index == `SBTC_IDX_COUNT_HI);
	assign hit_ctl      = addr_aligned && (bus_index == `SBTC_IDX_CONTROL);
	assign hit_any      = hit_status | hit_lo | hit_hi | hit_ctl;

	// zero wait states; unmapped addresses answer with an error
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit_any;
	assign setup_rd = psel & ~penable & ~pwrite;
	assign wr_en    = psel & penable & pwrite & hit_any;

	// per register write strobes
	assign wr_ctl      = wr_en & hit_ctl;
	assign wr_status   = wr_en & hit_status;
	assign wr_lo       = wr_en & hit_lo;
	assign wr_hi       = wr_en & hit_hi;
	// writing either count byte restarts the divider
	assign presc_clear = wr_lo | wr_hi;

	assign timer_on            = control_reg[`SBTC_CTL_TIMER_ON];
	assign clock_source_select = control_reg[`SBTC_CTL_CLK_SEL];
	assign sync_disable        = control_reg[`SBTC_CTL_SYNC_DIS];
	assign osc_enable          = control_reg[`SBTC_CTL_OSC_EN];
	assign prescale_select     = control_reg[`SBTC_CTL_PS_HI:`SBTC_CTL_PS_LO];

	// counting mode; sync_disable means nothing on the internal clock
	assign mode_timer = ~clock_source_select; // [RULE2]
	assign mode_sync  = clock_source_select & ~sync_disable; // [RULE4]
	assign mode_async = clock_source_select & sync_disable; // [RULE11]

	// both pins come from outside the clock domain
	sbtc_sync #(
		.W(2)
	) sbtc_sync_i (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.async_in ({osc_input_shared_pin, clock_input_shared_pin_i}),
		.sync_out (pins_sync)
	);

	assign osc_input_pin       = pins_sync[1];
	assign ext_count_clock_pin = pins_sync[0];

	// control register
	always @(posedge clk_sys) begin
		if (!resetn) begin
			control_reg <= `SBTC_CTL_RESET;
		end else if (wr_ctl) begin
			control_reg <= pwdata[7:0] & `SBTC_CTL_MASK;
		end
	end

	// instruction cycle phases, free running
	always @(posedge clk_sys) begin
		if (!resetn) begin
			phase_reg <= 2'h0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
		end
	end

	assign phase_two  = (phase_reg == `SBTC_PHASE_TWO);
	assign phase_four = (phase_reg == `SBTC_PHASE_FOUR);

	// oscillator amplifier: inverts the crystal input while enabled
	always @(posedge clk_sys) begin
		if (!resetn) begin
			clock_input_shared_pin_o  <= 1'b0;
			clock_input_shared_pin_oe <= 1'b0;
		end else begin
			clock_input_shared_pin_o  <= osc_enable & ~osc_input_pin; // [RULE16]
			clock_input_shared_pin_oe <= osc_enable; // [RULE16]
		end
	end

	// count source selection; sleep does not stop the oscillator path
	always @(posedge clk_sys) begin
		if (!resetn) begin
			src_reg      <= 1'b0;
			src_prev_reg <= 1'b0;
		end else begin
			src_reg      <= osc_enable ? osc_input_pin : ext_count_clock_pin; // [RULE3]
			src_prev_reg <= src_reg;
		end
	end

	assign src_rise = src_reg & ~src_prev_reg;

	// ripple divider: each stage toggles on the carry of the one below,
	// so every tap is a square wave
	always @* begin
		presc_next = presc_reg;
		if (presc_clear) begin
			presc_next = 3'h0;
		end else if (clock_source_select && src_rise) begin
			presc_next = presc_reg + 3'h1; // [RULE5] [RULE7]
		end
	end

	always @* begin
		case (prescale_select) // [RULE6]
			2'h0:    presc_out = src_reg;
			2'h1:    presc_out = presc_reg[0];
			2'h2:    presc_out = presc_reg[1];
			2'h3:    presc_out = presc_reg[2];
			default: presc_out = src_reg;
		endcase
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			presc_reg          <= 3'h0;
			presc_out_prev_reg <= 1'b0;
		end else begin
			presc_reg          <= presc_next;
			presc_out_prev_reg <= presc_out;
		end
	end

	assign presc_rise = presc_out & ~presc_out_prev_reg;

	// phase synchroniser after the prescaler; frozen in sleep, so a
	// synchronized counter holds even though the divider keeps going
	always @(posedge clk_sys) begin
		if (!resetn) begin
			samp_reg      <= 1'b0;
			samp_prev_reg <= 1'b0;
		end else if (!sleep_mode) begin // [RULE7]
			if (phase_two || phase_four) begin
				samp_reg <= presc_out; // [RULE4] [RULE8]
			end
			samp_prev_reg <= samp_reg;
		end
	end

	assign samp_rise = samp_reg & ~samp_prev_reg & ~sleep_mode;

	// increment source by mode
	always @* begin
		if (mode_timer) begin
			tick = phase_four; // [RULE1] [RULE2]
		end else if (mode_sync) begin
			tick = samp_rise; // [RULE8]
		end else begin
			tick = presc_rise; // [RULE11]
		end
	end

	assign wrap = timer_on & tick & (count_reg == 16'hFFFF);

	// a bus write to a byte wins over a coinciding increment
	always @* begin
		count_next = count_reg;
		if (timer_on && tick) begin
			count_next = count_reg + 16'h0001; // [RULE18]
		end
		if (wr_lo) begin
			count_next = {count_next[15:8], pwdata[7:0]}; // [RULE19]
		end
		if (wr_hi) begin
			count_next = {pwdata[7:0], count_next[7:0]}; // [RULE19]
		end
	end

	// overflow flag: write one to clear, a wrap in the same cycle wins
	always @* begin
		ovf_next = ovf_reg;
		if (wr_status && pwdata[`SBTC_STS_OVF]) begin
			ovf_next = 1'b0;
		end
		if (wrap) begin
			ovf_next = 1'b1; // [RULE18]
		end
	end

	always @(posedge clk_sys) begin
		if (!resetn) begin
			count_reg <= 16'h0000;
			ovf_reg   <= 1'b0;
		end else begin
			count_reg <= count_next;
			ovf_reg   <= ovf_next;
		end
	end

	// outputs toward the rest of the chip
	always @(posedge clk_sys) begin
		if (!resetn) begin
			count_value    <= 16'h0000;
			timebase_valid <= 1'b0;
			overflow_flag  <= 1'b0;
			overflow_wake  <= 1'b0;
		end else begin
			count_value    <= count_next;
			timebase_valid <= timer_on & ~mode_async; // [RULE12]
			overflow_flag  <= ovf_next;
			overflow_wake  <= wrap & sleep_mode & mode_async; // [RULE11]
		end
	end

	// read select; unmapped addresses read zero
	always @* begin
		rd_byte = 8'h00;
		if (hit_lo) begin
			rd_byte = count_reg[7:0]; // [RULE13] [RULE19]
		end else if (hit_hi) begin
			rd_byte = count_reg[15:8]; // [RULE13] [RULE19]
		end else if (hit_ctl) begin
			rd_byte = control_reg;
		end else if (hit_status) begin
			rd_byte = {7'h00, ovf_reg};
		end
	end

	// read data is captured in the setup cycle from the settled count,
	// so a byte never shows a half-updated value
	always @(posedge clk_sys) begin
		if (!resetn) begin
			prdata <= 32'h00000000;
		end else if (setup_rd) begin
			prdata <= {24'h000000, rd_byte};
		end
	end

endmodule // sbtc_top

`default_nettype wire

//--- hw/sbtc_consts.vh
`ifndef SBTC_CONSTS_VH
`define SBTC_CONSTS_VH

// register indices; byte address is four times the index
`define SBTC_IDX_STATUS     8'h0C
`define SBTC_IDX_COUNT_LO   8'h0E
`define SBTC_IDX_COUNT_HI   8'h0F
`define SBTC_IDX_CONTROL    8'h10

// timer_control fields
`define SBTC_CTL_TIMER_ON   0
`define SBTC_CTL_CLK_SEL    1
`define SBTC_CTL_SYNC_DIS   2
`define SBTC_CTL_OSC_EN     3
`define SBTC_CTL_PS_LO      4
`define SBTC_CTL_PS_HI      5
`define SBTC_CTL_MASK       8'h3F
`define SBTC_CTL_RESET      8'h00

// status fields
`define SBTC_STS_OVF        0

// instruction clock: system clock divided by four
`define SBTC_PHASE_TWO      2'h1
`define SBTC_PHASE_FOUR     2'h3

// clock and oscillator rating
`define SBTC_CLK_MHZ        50
`define SBTC_OSC_MAX_KHZ    200

`endif

//--- hw/sbtc_sync.v
`timescale 1ns/1ps
`default_nettype none

module sbtc_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         clk_sys,
	input  wire         resetn,
	// asynchronous level in, aligned level out
	input  wire [W-1:0] async_in,
	output wire [W-1:0] sync_out
);

	reg [W-1:0] stage1_reg;
	reg [W-1:0] stage2_reg;

	// first stage feeds only the second stage
	always @(posedge clk_sys) begin
		if (!resetn) begin
			stage1_reg <= {W{1'b0}};
			stage2_reg <= {W{1'b0}};
		end else begin
			stage1_reg <= async_in;
			stage2_reg <= stage1_reg;
		end
	end

	assign sync_out = stage2_reg;

endmodule // sbtc_sync

`default_nettype wire

//--- tb/sbtc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_consts.vh"
module sbtc_checker (
	// clock, reset and bus
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] prdata,
	// power state and amplifier pin
	input wire logic        sleep_mode,
	input wire logic        clock_input_shared_pin_o,
	input wire logic        clock_input_shared_pin_oe,
	// counter side
	input wire logic [15:0] count_value,
	input wire logic        timebase_valid,
	input wire logic        overflow_flag,
	input wire logic        overflow_wake
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	wire acc = psel && penable;
	wire mapped = paddr == {2'h0, `SBTC_IDX_STATUS, 2'h0} || paddr == {2'h0, `SBTC_IDX_COUNT_LO, 2'h0}
		|| paddr == {2'h0, `SBTC_IDX_COUNT_HI, 2'h0} || paddr == {2'h0, `SBTC_IDX_CONTROL, 2'h0};
	a_ready_high: assert property (acc |-> pready) else $error("no ready");
	a_slverr_map: assert property (acc |-> pslverr == !mapped) else $error("bad slverr");
	a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
		else $error("unmapped data");
	a_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
		else $error("read data moved");
	a_count_step: assert property ($changed(count_value) && !$past(acc && pwrite)
		|-> count_value - $past(count_value) == 16'h1) else $error("count jump");
	a_wrap_flag: assert property ($past(count_value) == 16'hFFFF && count_value == 16'h0
		|-> ##[0:1] overflow_flag) else $error("no flag on wrap");
	a_wake_pulse: assert property (overflow_wake |=> !overflow_wake) else $error("long wake");
	a_wake_async: assert property (overflow_wake |-> !timebase_valid) else $error("wake base");
	a_wake_sleep: assert property (overflow_wake |-> $past(sleep_mode) && overflow_flag)
		else $error("wake while awake");
	a_amp_quiet: assert property (!clock_input_shared_pin_oe
		|-> !clock_input_shared_pin_o) else $error("amp drives while off");
endmodule // sbtc_checker
bind sbtc_top sbtc_checker sbtc_checker_i (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr,
	.pready, .pslverr, .prdata, .count_value, .timebase_valid, .overflow_flag, .overflow_wake,
	.sleep_mode, .clock_input_shared_pin_o, .clock_input_shared_pin_oe);
`default_nettype wire

//--- tb/sbtc_ext_src.sv
`timescale 1ns/1ps
`default_nettype none
module sbtc_ext_src (
	// clock and source select
	input  wire logic clk_sys,
	input  wire logic use_osc,
	// source pins, standing low while idle
	output wire logic ext_pin,
	output wire logic osc_pin
);
	logic lvl = 1'b0;
	// four clocks high and low: legal at every prescale
	task automatic pulses(input int n);
		repeat (n) begin
			repeat (4) @(posedge clk_sys);
			lvl <= 1'b1;
			repeat (4) @(posedge clk_sys);
			lvl <= 1'b0;
		end
	endtask
	assign ext_pin = use_osc ? 1'b0 : lvl;
	assign osc_pin = use_osc ? lvl : 1'b0;
endmodule // sbtc_ext_src
`default_nettype wire

//--- tb/sbtc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbtc_consts.vh"
module sbtc_top_test;
	localparam [7:0] ctl = `SBTC_IDX_CONTROL, lo = `SBTC_IDX_COUNT_LO, hi = `SBTC_IDX_COUNT_HI;
	logic        clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, v;
	logic        pready, pslverr, clock_input_shared_pin_o, clock_input_shared_pin_oe;
	logic        overflow_wake, ext_pin, osc_input_shared_pin, use_osc = 0, woke = 0;
	int          num_errors = 0, total_checks = 0, seed = 17, ps, osc;
	logic [31:0] exq[$];
	// the shared pin carries the amplifier output while the design drives it
	wire logic   clock_input_shared_pin_i =
		clock_input_shared_pin_oe ? clock_input_shared_pin_o : ext_pin;
	always #10 clk_sys = ~clk_sys;
	sbtc_top sbtc_top_i (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
		.pslverr, .prdata, .sleep_mode, .osc_input_shared_pin, .clock_input_shared_pin_i,
		.clock_input_shared_pin_o, .clock_input_shared_pin_oe, .count_value(),
		.timebase_valid(), .overflow_flag(), .overflow_wake);
	sbtc_ext_src sbtc_ext_src_i (.clk_sys, .use_osc, .ext_pin, .osc_pin(osc_input_shared_pin));
	task check(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// idle edge first, so psel is never assigned twice in one step
	task xfer(input logic [7:0] idx, input logic w, input logic [31:0] d);
		@(posedge clk_sys);
		paddr <= {2'h0, idx, 2'h0};
		pwrite <= w;
		pwdata <= d;
		psel <= 1'b1;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] idx, input logic [31:0] d);
		xfer(idx, 1'b1, d);
	endtask
	task rd(input logic [7:0] idx, input logic [31:0] e);
		exq.push_back(e);
		xfer(idx, 1'b0, 32'h0);
	endtask
	task run(input int n);
		sbtc_ext_src_i.pulses(n);
		repeat (12) @(posedge clk_sys);
		sleep_mode <= 1'b0;
		wr(ctl, 32'h0);
	endtask
	task results;
		$display("errors %0d checks %0d", num_errors, total_checks);
		if (num_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		if (overflow_wake)
			woke <= 1'b1;
		if (psel && penable && !pwrite && pready)
			check(prdata, exq.pop_front());
	end
	initial begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		results;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(ctl, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h11, 32'h0);
		v = $random(seed);
		wr(ctl, v);
		rd(ctl, v & 32'h3F);
		wr(ctl, 32'h0);
		wr(lo, v >> 8);
		wr(hi, v >> 16);
		rd(lo, (v >> 8) & 32'hFF);
		rd(hi, (v >> 16) & 32'hFF);
		// 400 enabled edges give exactly 100 instruction cycles
		for (ps = 0; ps < 2; ps++) begin
			wr(lo, 32'h0);
			wr(hi, 32'h0);
			wr(ctl, ps ? 32'h5 : 32'h1);
			repeat (397) @(posedge clk_sys);
			wr(ctl, 32'h0);
			rd(lo, 32'h64);
			rd(hi, 32'h0);
		end
		for (osc = 0; osc < 2; osc++)
			for (ps = 0; ps < 4; ps++) begin
				use_osc <= osc[0];
				wr(lo, 32'h0);
				wr(hi, 32'h0);
				wr(ctl, 32'h3 | osc << 3 | ps << 4);
				repeat (20) @(posedge clk_sys); // start-up allowance
				check(clock_input_shared_pin_oe, osc);
				run(16);
				rd(lo, 16 >> ps);
			end
		use_osc <= 1'b0;
		wr(lo, 32'h0);
		wr(ctl, 32'h3);
		sleep_mode <= 1'b1;
		run(8);
		rd(lo, 32'h0);
		wr(lo, 32'hFC);
		wr(hi, 32'hFF);
		wr(ctl, 32'h7);
		sleep_mode <= 1'b1;
		run(8);
		rd(hi, 32'h0);
		rd(lo, 32'h4);
		rd(hi, 32'h0);
		rd(8'h0C, 32'h1);
		check(woke, 32'h1);
		wr(8'h0C, 32'h1);
		rd(8'h0C, 32'h0);
		@(posedge clk_sys);
		results;
	end
endmodule // sbtc_top_test
`default_nettype wire
